// >>> rtl/csfm_pkg.sv
/*
  Constants for the clock switch and fail-safe monitor: register offsets,
  field positions, unlock keys, group codes and event bits.
  Assumes an AHB-Lite fabric with 32-bit data and whole-word transfers.
*/
// How it works
// RQ1: Monitor select upper bit disables switching, monitoring.
// RQ2: Monitoring keeps low-power RC running except Sleep.
// RQ3: Failure raises trap and selects fast RC.
// RQ4: Failure loads group, sets fail flag, clears enable.
// RQ5: Failure leaves watchdog running on low-power RC.
// RQ6: Timer expiry before oscillator start forces failure.
// RQ7: Switching only between four groups, never within.
// RQ8: Primary option comes only from primary select.
// RQ9: Current group read-only; new group writable request.
// RQ10: Power-on and brown-out load both groups from config.
// RQ11: Lock bit reports PLL lock.
// RQ12: Enable sets on switch start; clearing aborts it.
// RQ13: Switching disabled: config fields choose, current mirrors.
// RQ14: Software avoids clocks below 100 kHz when monitored.
// RQ15: Low byte unlocks with 0x46 then 0x57.
// RQ16: High byte unlocks with 0x78 then 0x9a.
// RQ17: Unlocked byte accepts only the next single write.
// RQ18: Writes outside the unlock window change nothing.
// RQ19: No edges within low-power RC window means failure.
package csfm_pkg;
  // Register byte addresses.
  localparam logic [7:0] OSC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] OSC_LOW_BYTE_ADDR = 8'h04;
  localparam logic [7:0] OSC_HIGH_BYTE_ADDR = 8'h08;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h0c;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h10;
  localparam logic [7:0] IRQ_CLEAR_ADDR = 8'h14;
  // Oscillator control field positions.
  localparam int CUR_GROUP_LSB = 12;
  localparam int NEW_GROUP_LSB = 8;
  localparam int LOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int SWEN_BIT = 0;
  // Unlock keys.
  localparam logic [7:0] LOW_KEY_1 = 8'h46;
  localparam logic [7:0] LOW_KEY_2 = 8'h57;
  localparam logic [7:0] HIGH_KEY_1 = 8'h78;
  localparam logic [7:0] HIGH_KEY_2 = 8'h9a;
  // Group codes.
  localparam logic [2:0] GRP_LOW_POWER_RC = 3'h0;
  localparam logic [2:0] GRP_FAST_RC = 3'h1;
  localparam logic [2:0] GRP_SECONDARY = 3'h2;
  localparam logic [2:0] GRP_PRIMARY = 3'h3;
  // Interrupt event bits.
  localparam int EV_FAIL = 0;
  localparam int EV_SWITCH_DONE = 1;
  localparam int EV_SWITCH_ABORT = 2;
  localparam int EV_NUM = 3;
  // Failure window in low-power RC ticks.
  localparam logic [3:0] FAIL_WINDOW_TICKS = 4'h4;
  // AHB constants.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {
    CSFM_SW_IDLE,
    CSFM_SW_WAIT
  } csfm_sw_state_e;
  typedef enum logic [1:0] {
    CSFM_UL_LOCKED,
    CSFM_UL_KEY1,
    CSFM_UL_OPEN
  } csfm_unlock_e;
endpackage

// >>> rtl/csfm_top.sv
/*
  Clock switch and fail-safe monitor with an AHB-Lite register slave.
  Assumes oscillator status inputs are synchronous to hclk, that
  low_power_rc_osc_tick pulses once per low-power RC period and sys_osc_edge pulses
  whenever the running oscillator shows an edge.
*/
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`default_nettype none
module csfm_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] clock_monitor_select,
  input wire logic [2:0] initial_group,
  input wire logic [4:0] primary_select,
  input wire logic por_bor_event,
  input wire logic sleep_mode,
  input wire logic soft_watchdog_enable,
  input wire logic pll_locked,
  input wire logic low_power_rc_osc_tick,
  input wire logic sys_osc_edge,
  input wire logic power_up_timer_done,
  input wire logic osc_running,
  input wire logic new_osc_ready,
  output logic [2:0] sel_group,
  output logic [4:0] sel_primary,
  output logic low_power_rc_osc_run,
  output logic watchdog_timer_run,
  output logic clock_fail_trap,
  output logic irq
);
  import csfm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave.
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [2:0] cur_group_r;
  logic [2:0] new_group_r;
  logic fail_flag_r;
  logic swen_r;
  logic lock_r;
  logic [EV_NUM-1:0] irq_status_r;
  logic [EV_NUM-1:0] irq_enable_r;
  logic [31:0] rdata_nxt;
  logic [15:0] ctrl_word;
  logic addr_phase;

  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign ctrl_word = {1'b0, cur_group_r, 1'b0, new_group_r, 2'b00, lock_r, 1'b0,
                      fail_flag_r, 2'b00, swen_r};

  always_comb begin
    rdata_nxt = ZERO_WORD;
    unique case (haddr[7:0])
      OSC_CTRL_ADDR: rdata_nxt = {16'h0000, ctrl_word};
      IRQ_STATUS_ADDR: rdata_nxt = {29'h0000_0000, irq_status_r};
      IRQ_ENABLE_ADDR: rdata_nxt = {29'h0000_0000, irq_enable_r};
      default: rdata_nxt = ZERO_WORD;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_phase && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= ZERO_WORD;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rdata_nxt;
    end
  end

  // Zero wait states, so every transfer ends in its first data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Any transfer that is not the expected next step closes an unlock.
  logic xfer_done_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_done_r <= 1'b0;
    end else begin
      xfer_done_r <= addr_phase;
    end
  end

  logic wr_low;
  logic wr_high;
  assign wr_low = wr_pend_r && (wr_addr_r == OSC_LOW_BYTE_ADDR);
  assign wr_high = wr_pend_r && (wr_addr_r == OSC_HIGH_BYTE_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Unlock sequencers, one per byte.
  csfm_unlock_e low_ul_r;
  csfm_unlock_e high_ul_r;
  logic low_open_wr;
  logic high_open_wr;

  assign low_open_wr = wr_low && (low_ul_r == CSFM_UL_OPEN); // RQ17
  assign high_open_wr = wr_high && (high_ul_r == CSFM_UL_OPEN); // RQ17

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_ul_r <= CSFM_UL_LOCKED;
    end else if (xfer_done_r) begin
      if (!wr_low) begin
        low_ul_r <= CSFM_UL_LOCKED; // RQ15
      end else begin
        unique case (low_ul_r)
          CSFM_UL_LOCKED: low_ul_r <= (hwdata[7:0] == LOW_KEY_1) ? CSFM_UL_KEY1
                                                             : CSFM_UL_LOCKED; // RQ15
          CSFM_UL_KEY1: low_ul_r <= (hwdata[7:0] == LOW_KEY_2) ? CSFM_UL_OPEN
                                                           : CSFM_UL_LOCKED; // RQ15
          default: low_ul_r <= CSFM_UL_LOCKED; // RQ17
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_ul_r <= CSFM_UL_LOCKED;
    end else if (xfer_done_r) begin
      if (!wr_high) begin
        high_ul_r <= CSFM_UL_LOCKED; // RQ16
      end else begin
        unique case (high_ul_r)
          CSFM_UL_LOCKED: high_ul_r <= (hwdata[7:0] == HIGH_KEY_1) ? CSFM_UL_KEY1
                                                               : CSFM_UL_LOCKED; // RQ16
          CSFM_UL_KEY1: high_ul_r <= (hwdata[7:0] == HIGH_KEY_2) ? CSFM_UL_OPEN
                                                             : CSFM_UL_LOCKED; // RQ16
          default: high_ul_r <= CSFM_UL_LOCKED; // RQ17
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode.
  logic switch_allowed;
  logic monitor_on;
  logic req_legal;
  logic [2:0] req_group;
  assign switch_allowed = !clock_monitor_select[1]; // RQ1
  assign monitor_on = (clock_monitor_select == 2'b00); // RQ1
  assign req_group = hwdata[NEW_GROUP_LSB-8 +: 3];
  // Only the four group codes exist, so options within a group never switch.
  assign req_legal = (req_group == GRP_LOW_POWER_RC) || (req_group == GRP_FAST_RC) ||
                     (req_group == GRP_SECONDARY) || (req_group == GRP_PRIMARY); // RQ7

  ////////////////////////////////////////////////////////////////////////////
  // Failure monitor.
  logic [3:0] silent_ticks_r;
  logic fail_det;
  logic start_fail;
  assign start_fail = monitor_on && power_up_timer_done && !osc_running; // RQ6
  assign fail_det = monitor_on && !sleep_mode && (cur_group_r != GRP_FAST_RC) &&
                    ((silent_ticks_r >= FAIL_WINDOW_TICKS) || start_fail); // RQ3

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      silent_ticks_r <= 4'h0;
    end else if (sys_osc_edge || !monitor_on || sleep_mode || fail_det) begin
      silent_ticks_r <= 4'h0; // RQ19
    end else if (low_power_rc_osc_tick && silent_ticks_r < FAIL_WINDOW_TICKS) begin
      silent_ticks_r <= silent_ticks_r + 4'h1; // RQ19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch sequencer and control fields.
  csfm_sw_state_e sw_state_r;
  logic cfg_load_r;
  logic sw_done;
  logic sw_abort;
  assign sw_done = (sw_state_r == CSFM_SW_WAIT) && swen_r && new_osc_ready && !fail_det;
  assign sw_abort = (sw_state_r == CSFM_SW_WAIT) && !swen_r && !fail_det; // RQ12

  // Groups load once at the first edge after reset release, never under reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_load_r <= 1'b1;
    end else begin
      cfg_load_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_state_r <= CSFM_SW_IDLE;
    end else if (fail_det || cfg_load_r || por_bor_event || !switch_allowed) begin
      sw_state_r <= CSFM_SW_IDLE;
    end else begin
      unique case (sw_state_r)
        CSFM_SW_IDLE: if (swen_r && new_group_r != cur_group_r) begin
          sw_state_r <= CSFM_SW_WAIT;
        end
        CSFM_SW_WAIT: if (sw_done || sw_abort) begin
          sw_state_r <= CSFM_SW_IDLE; // RQ12
        end
        default: sw_state_r <= CSFM_SW_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_group_r <= GRP_FAST_RC;
    end else if (cfg_load_r || por_bor_event || !switch_allowed) begin
      cur_group_r <= initial_group; // RQ10 RQ13
    end else if (fail_det) begin
      cur_group_r <= GRP_FAST_RC; // RQ4 RQ6
    end else if (sw_done) begin
      cur_group_r <= new_group_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      new_group_r <= GRP_FAST_RC;
    end else if (cfg_load_r || por_bor_event) begin
      new_group_r <= initial_group; // RQ10
    end else if (high_open_wr && req_legal) begin
      new_group_r <= req_group; // RQ9 RQ18
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      swen_r <= 1'b0;
    end else if (fail_det || cfg_load_r || por_bor_event || !switch_allowed) begin
      swen_r <= 1'b0; // RQ4
    end else if (low_open_wr) begin
      swen_r <= hwdata[SWEN_BIT]; // RQ12 RQ18
    end else if (sw_done || (sw_state_r == CSFM_SW_IDLE && swen_r &&
                             new_group_r == cur_group_r)) begin
      swen_r <= 1'b0;
    end
  end

  // The fail flag is read-only; only a reset or a power event clears it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fail_flag_r <= 1'b0;
    end else if (fail_det) begin
      fail_flag_r <= 1'b1; // RQ4
    end else if (cfg_load_r || por_bor_event) begin
      fail_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_r <= 1'b0;
    end else begin
      lock_r <= pll_locked; // RQ11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock selection outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_group <= GRP_FAST_RC;
      sel_primary <= 5'h00;
    end else begin
      sel_group <= switch_allowed ? cur_group_r : initial_group; // RQ13
      sel_primary <= primary_select; // RQ8
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_power_rc_osc_run <= 1'b0;
      watchdog_timer_run <= 1'b0;
    end else begin
      low_power_rc_osc_run <= !sleep_mode && (monitor_on || soft_watchdog_enable); // RQ2
      watchdog_timer_run <= soft_watchdog_enable; // RQ5
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_fail_trap <= 1'b0;
    end else begin
      clock_fail_trap <= fail_det; // RQ3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and clear; a new event wins over a clear.
  logic [EV_NUM-1:0] events;
  logic [EV_NUM-1:0] clr_mask;
  assign events = {sw_abort, sw_done, fail_det};
  assign clr_mask = (wr_pend_r && wr_addr_r == IRQ_CLEAR_ADDR) ? hwdata[EV_NUM-1:0]
                                                              : {EV_NUM{1'b0}};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_r <= {EV_NUM{1'b0}};
    end else begin
      irq_status_r <= (irq_status_r & ~clr_mask) | events;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable_r <= {EV_NUM{1'b0}};
    end else if (wr_pend_r && wr_addr_r == IRQ_ENABLE_ADDR) begin
      irq_enable_r <= hwdata[EV_NUM-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status_r & ~clr_mask) | events) & irq_enable_r);
    end
  end
endmodule
`default_nettype wire

// >>> tb/csfm_properties.sv
/*
  Port checker for the clock switch and fail-safe monitor.
  Assumes one hclk domain and a bind onto csfm_top.
*/
`timescale 1ns/100ps
`default_nettype none
module csfm_properties
  import csfm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] clock_monitor_select,
  input wire logic [2:0] initial_group,
  input wire logic [4:0] primary_select,
  input wire logic sleep_mode,
  input wire logic soft_watchdog_enable,
  input wire logic [2:0] sel_group,
  input wire logic [4:0] sel_primary,
  input wire logic low_power_rc_osc_run,
  input wire logic watchdog_timer_run,
  input wire logic clock_fail_trap
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  chk_monitor_off: assert property (
    clock_monitor_select[1] && $past(clock_monitor_select[1]) |-> !clock_fail_trap)
    else $error("trap raised with monitoring disabled");
  chk_low_power_rc_osc_run: assert property ($past(hresetn) |-> low_power_rc_osc_run ==
    $past(!sleep_mode && (clock_monitor_select == 2'h0 || soft_watchdog_enable)))
    else $error("low-power RC run level wrong");
  chk_trap_pulse: assert property (clock_fail_trap |=> !clock_fail_trap)
    else $error("trap longer than one cycle");
  chk_trap_to_fast: assert property (
    $rose(clock_fail_trap) |-> ##[0:2] sel_group == GRP_FAST_RC)
    else $error("trap without move to fast RC");
  chk_wdt_kept: assert property (
    $past(hresetn) |-> watchdog_timer_run == $past(soft_watchdog_enable))
    else $error("watchdog run level wrong");
  chk_primary_copy: assert property ($past(hresetn, 2) &&
    primary_select == $past(primary_select) && primary_select == $past(primary_select, 2)
    |-> sel_primary == primary_select) else $error("primary option not copied");
  chk_sleep_quiet: assert property (sleep_mode && $past(sleep_mode) |-> !clock_fail_trap)
    else $error("trap raised during sleep");
  chk_group_config: assert property (clock_monitor_select[1] && $past(hresetn, 3) &&
    $past(clock_monitor_select[1], 3) && initial_group == $past(initial_group, 3)
    |-> sel_group == initial_group) else $error("group does not follow config");
  cov_trap: cover property (clock_fail_trap);
  cov_secondary: cover property ($rose(sel_group == GRP_SECONDARY));
  cov_low_power_rc_osc_on: cover property ($rose(low_power_rc_osc_run));
endmodule
bind csfm_top csfm_properties chk_u (.hclk, .hresetn, .clock_monitor_select,
  .initial_group, .primary_select, .sleep_mode, .soft_watchdog_enable, .sel_group,
  .sel_primary, .low_power_rc_osc_run, .watchdog_timer_run, .clock_fail_trap);
`default_nettype wire

// >>> tb/csfm_top_bench.sv
/*
  Self-checking bench for csfm_top: registers over AHB-Lite, switching, failures.
  Assumes zero wait states and the register map of csfm_pkg.
*/
`timescale 1ns/100ps
`default_nettype none
module csfm_top_bench;
  import csfm_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, dummy;
  logic [1:0] htrans = 2'h0, clock_monitor_select = 2'h0;
  logic hwrite = 1'b0, por_bor_event = 1'b0, sleep_mode = 1'b0, soft_watchdog_enable = 1'b1;
  logic pll_locked = 1'b1, low_power_rc_osc_tick = 1'b0, sys_osc_edge = 1'b0, new_osc_ready = 1'b0;
  logic power_up_timer_done = 1'b0, osc_running = 1'b1;
  logic [2:0] initial_group = GRP_PRIMARY, sel_group;
  logic [4:0] primary_select = 5'h0b, sel_primary;
  logic hreadyout, hresp, low_power_rc_osc_run, watchdog_timer_run, clock_fail_trap, irq;
  int n_fail = 0, num_checks = 0, n_trap = 0;
  csfm_top dut_u (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .clock_monitor_select,
    .initial_group, .primary_select, .por_bor_event, .sleep_mode, .soft_watchdog_enable,
    .pll_locked, .low_power_rc_osc_tick, .sys_osc_edge, .power_up_timer_done, .osc_running,
    .new_osc_ready, .sel_group, .sel_primary, .low_power_rc_osc_run, .watchdog_timer_run,
    .clock_fail_trap, .irq);
  always #2 hclk = ~hclk;
  always @(posedge hclk) begin
    if (clock_fail_trap === 1'b1) n_trap++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, dummy);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(v, exp);
    check({hreadyout, hresp}, 32'h2);
  endtask
  // Both keys and the value go out as three consecutive transfers.
  task automatic unlock_wr(input logic [7:0] a, k1, k2, v);
    wr(a, {24'h0, k1});
    wr(a, {24'h0, k2});
    wr(a, {24'h0, v});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic tick(input int n, input logic e);
    repeat (n) begin
      low_power_rc_osc_tick <= 1'b1;
      sys_osc_edge <= e;
      @(posedge hclk);
      low_power_rc_osc_tick <= 1'b0;
      sys_osc_edge <= 1'b0;
      cyc(2);
    end
  endtask
  task automatic wait_grp(input logic [2:0] g);
    for (int i = 0; i < 20 && sel_group !== g; i++) cyc(1);
    check(sel_group, g);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(OSC_CTRL_ADDR, 32'h3320);
    check(sel_group, GRP_PRIMARY);
    check(sel_primary, 5'h0b);
    pll_locked <= 1'b0;
    wr(OSC_CTRL_ADDR, 32'hffff);
    rd_chk(OSC_CTRL_ADDR, 32'h3300);
    pll_locked <= 1'b1;
    wr(8'h40, 32'h1);
    rd_chk(8'h40, 32'h0);
  endtask
  task automatic t_unlock;
    wr(OSC_HIGH_BYTE_ADDR, 32'h2);
    rd_chk(OSC_CTRL_ADDR, 32'h3320);
    wr(OSC_HIGH_BYTE_ADDR, 32'h78);
    bus(1'b0, OSC_CTRL_ADDR, 32'h0, dummy);
    wr(OSC_HIGH_BYTE_ADDR, 32'h9a);
    wr(OSC_HIGH_BYTE_ADDR, 32'h2);
    rd_chk(OSC_CTRL_ADDR, 32'h3320);
    unlock_wr(OSC_LOW_BYTE_ADDR, 8'h57, 8'h46, 8'h01);
    rd_chk(OSC_CTRL_ADDR, 32'h3320);
    unlock_wr(OSC_HIGH_BYTE_ADDR, 8'h78, 8'h9a, 8'h02);
    wr(OSC_HIGH_BYTE_ADDR, 32'h1);
    rd_chk(OSC_CTRL_ADDR, 32'h3220);
  endtask
  task automatic t_switch;
    wr(IRQ_ENABLE_ADDR, 32'h7);
    rd_chk(IRQ_ENABLE_ADDR, 32'h7);
    unlock_wr(OSC_LOW_BYTE_ADDR, 8'h46, 8'h57, 8'h01);
    rd_chk(OSC_CTRL_ADDR, 32'h3221);
    new_osc_ready <= 1'b1;
    wait_grp(GRP_SECONDARY);
    rd_chk(OSC_CTRL_ADDR, 32'h2220);
    rd_chk(IRQ_STATUS_ADDR, 32'h2);
    check(irq, 1'b1);
    wr(IRQ_CLEAR_ADDR, 32'h2);
    new_osc_ready <= 1'b0;
    cyc(3);
    check(irq, 1'b0);
  endtask
  task automatic t_abort;
    unlock_wr(OSC_HIGH_BYTE_ADDR, 8'h78, 8'h9a, 8'h00);
    unlock_wr(OSC_LOW_BYTE_ADDR, 8'h46, 8'h57, 8'h01);
    rd_chk(OSC_CTRL_ADDR, 32'h2021);
    unlock_wr(OSC_LOW_BYTE_ADDR, 8'h46, 8'h57, 8'h00);
    rd_chk(OSC_CTRL_ADDR, 32'h2020);
    rd_chk(IRQ_STATUS_ADDR, 32'h4);
    check(sel_group, GRP_SECONDARY);
    wr(IRQ_CLEAR_ADDR, 32'h4);
  endtask
  task automatic t_fail;
    wr(IRQ_ENABLE_ADDR, 32'h0);
    tick(3, 1'b0);
    check(n_trap, 0);
    tick(1, 1'b0);
    cyc(3);
    check(n_trap, 1);
    wait_grp(GRP_FAST_RC);
    rd_chk(OSC_CTRL_ADDR, 32'h1028);
    check(watchdog_timer_run, 1'b1);
    check(irq, 1'b0);
    wr(IRQ_ENABLE_ADDR, 32'h1);
    cyc(3);
    check(irq, 1'b1);
    wr(IRQ_CLEAR_ADDR, 32'h1);
    cyc(3);
    check(irq, 1'b0);
  endtask
  task automatic t_startup;
    por_bor_event <= 1'b1;
    @(posedge hclk);
    por_bor_event <= 1'b0;
    cyc(3);
    rd_chk(OSC_CTRL_ADDR, 32'h3320);
    power_up_timer_done <= 1'b1;
    osc_running <= 1'b0;
    cyc(4);
    check(n_trap, 2);
    rd_chk(OSC_CTRL_ADDR, 32'h1328);
    power_up_timer_done <= 1'b0;
    osc_running <= 1'b1;
  endtask
  // A reset keeps the config change away from a half-finished switch.
  task automatic t_disabled;
    clock_monitor_select <= 2'h2;
    hresetn <= 1'b0;
    cyc(3);
    hresetn <= 1'b1;
    cyc(4);
    check(sel_group, GRP_PRIMARY);
    unlock_wr(OSC_HIGH_BYTE_ADDR, 8'h78, 8'h9a, 8'h02);
    unlock_wr(OSC_LOW_BYTE_ADDR, 8'h46, 8'h57, 8'h01);
    rd_chk(OSC_CTRL_ADDR, 32'h3220);
    check(sel_group, GRP_PRIMARY);
    soft_watchdog_enable <= 1'b0;
    tick(6, 1'b0);
    check(n_trap, 2);
    check(low_power_rc_osc_run, 1'b0);
    clock_monitor_select <= 2'h0;
    sleep_mode <= 1'b1;
    tick(6, 1'b0);
    check(n_trap, 2);
    check(low_power_rc_osc_run, 1'b0);
    sleep_mode <= 1'b0;
    tick(1, 1'b1);
    check(low_power_rc_osc_run, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(2);
    t_reset();
    t_unlock();
    t_switch();
    t_abort();
    t_fail();
    t_startup();
    t_disabled();
    finish_test();
  end
endmodule
`default_nettype wire
